/* logic/io_api_map.vh */
`ifndef IO_API_MAP_VH
`define IO_API_MAP_VH

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define FN_RD_BOOL   8'h01
`define FN_RD_WORD   8'h03
`define FN_RD_RO     8'h04
`define FN_WR_BOOL   8'h0F
`define FN_WR_WORD   8'h10
`define FN_ERR_FLAG  8'h80

// ----------------------------------------------------------------
// error codes
// ----------------------------------------------------------------
`define ERR_NONE     8'h00
`define ERR_FUNC     8'h01
`define ERR_ADDR     8'h02
`define ERR_VALUE    8'h03
`define ERR_FAIL     8'h04

// ----------------------------------------------------------------
// request layout and limits
// ----------------------------------------------------------------
`define HDR_LAST     3'h4
`define HDR_FUNC     3'h0
`define HDR_START_HI 3'h1
`define HDR_START_LO 3'h2
`define HDR_CNT_HI   3'h3
`define MAX_BOOL_CNT 17'h007D0
`define MAX_WORD_CNT 17'h0007D
`define BOOLS_PER_BYTE 17'h00008

`endif

/* logic/io_byte_fifo.v */
`default_nettype none

// ----------------------------------------------------------------
// response byte queue
// ----------------------------------------------------------------
module io_byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             rst_n,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam AW = $clog2(DEPTH);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      fill_ff;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (fill_ff != DEPTH[AW:0]);
  assign out_valid = (fill_ff != {(AW+1){1'b0}});
  assign out_data  = mem_ff[rd_ptr_ff];

  always @(posedge clk_sys) begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end

  // pointers wrap by modulo so depth need not be a power of two
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      fill_ff   <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      if (push && !pop)
        fill_ff <= fill_ff + 1'b1;
      else if (pop && !push)
        fill_ff <= fill_ff - 1'b1;
    end
  end
endmodule

`default_nettype wire

/* logic/io_word_ram.v */
`default_nettype none

// ----------------------------------------------------------------
// read/write word register store, registered read
// ----------------------------------------------------------------
module io_word_ram #(
  parameter DW    = 16,
  parameter DEPTH = 32
) (
  // clock
  input  wire                     clk_sys,
  // write port
  input  wire                     wr_en,
  input  wire [$clog2(DEPTH)-1:0] wr_addr,
  input  wire [DW-1:0]            wr_data,
  // read port
  input  wire [$clog2(DEPTH)-1:0] rd_addr,
  output reg  [DW-1:0]            rd_data_ff
);
  reg [DW-1:0] mem_ff [0:DEPTH-1];

  always @(posedge clk_sys) begin
    if (wr_en)
      mem_ff[wr_addr] <= wr_data;
    rd_data_ff <= mem_ff[rd_addr];
  end
endmodule

`default_nettype wire

/* logic/io_api_engine.v */
// How it works
// - codes 01,03,04 read bool, word, read-only
// - codes 0F,10 write bool and word registers
// - two-byte start then two-byte count follow code
// - write payload after count, big endian words
// - paired registers never split by an access
// - echo code, top bit set on failure
// - second byte is length or error code
// - booleans packed from bit 0, eight per byte
// - word data sent high byte first
// - unsupported code gives error 01
// - bad address or range gives error 02
// - bad data value gives error 03
// - fault seen in the check cycle of a valid request gives error 04
`include "io_api_map.vh"
`default_nettype none

module io_api_engine #(
  parameter NBOOL      = 16,
  parameter NWORD      = 32,
  parameter NRO        = 16,
  parameter PAIR_BASE  = 16,
  parameter FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire                clk_sys,
  input  wire                rst_n,
  // request byte stream
  input  wire                rx_valid,
  input  wire [7:0]          rx_data,
  output wire                rx_ready,
  // response byte stream
  output wire                tx_valid,
  input  wire                tx_ready,
  output wire [7:0]          tx_data,
  // i/o register space
  output wire [NBOOL-1:0]    bool_out,
  input  wire [NRO*16-1:0]   ro_regs,
  input  wire                io_fault
);
  localparam WAW = $clog2(NWORD);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [7:0] S_HDR   = 8'h01;
  localparam [7:0] S_CHK   = 8'h02;
  localparam [7:0] S_PAY   = 8'h04;
  localparam [7:0] S_CODE  = 8'h08;
  localparam [7:0] S_LEN   = 8'h10;
  localparam [7:0] S_FETCH = 8'h20;
  localparam [7:0] S_WORD  = 8'h40;
  localparam [7:0] S_BOOL  = 8'h80;

  reg [7:0]       state_ff;
  reg [7:0]       nxt_state;
  reg [2:0]       hdr_cnt_ff;
  reg [7:0]       func_ff;
  reg [15:0]      start_ff;
  reg [15:0]      count_ff;
  reg [7:0]       err_ff;
  reg [7:0]       len_ff;
  reg [16:0]      pay_ff;
  reg [16:0]      idx_ff;
  reg [16:0]      rem_ff;
  reg             phase_ff;
  reg [7:0]       hi_ff;
  reg [NBOOL-1:0] bool_ff;
  integer         j;
  integer         k;

  wire [15:0] ram_rdata;
  wire        fifo_in_ready;
  reg         fifo_in_valid;
  reg  [7:0]  fifo_in_data;

  wire take = rx_valid & rx_ready;
  wire push = fifo_in_valid & fifo_in_ready;

  // the request is taken back to back; a stall mid-request would simply
  // wait, since there is no gap timeout to resynchronise on
  assign rx_ready = (state_ff == S_HDR) || (state_ff == S_PAY);
  assign bool_out = bool_ff;

  // ----------------------------------------------------------------
  // request decode and checks
  // ----------------------------------------------------------------
  wire is_rd_bool = (func_ff == `FN_RD_BOOL);
  wire is_rd_word = (func_ff == `FN_RD_WORD);
  wire is_rd_ro   = (func_ff == `FN_RD_RO);
  wire is_wr_bool = (func_ff == `FN_WR_BOOL);
  wire is_wr_word = (func_ff == `FN_WR_WORD);
  wire is_bool    = is_rd_bool | is_wr_bool;
  wire is_write   = is_wr_bool | is_wr_word;
  wire func_ok    = is_bool | is_rd_word | is_rd_ro | is_wr_word;

  wire [16:0] cnt17   = {1'b0, count_ff};
  wire [16:0] end_c   = {1'b0, start_ff} + cnt17;
  wire [16:0] bytes_c = (cnt17 + 17'h00007) >> 3;
  wire [16:0] limit_c = is_bool ? NBOOL[16:0] : (is_rd_ro ? NRO[16:0] : NWORD[16:0]);
  wire [16:0] maxq_c  = is_bool ? `MAX_BOOL_CNT : `MAX_WORD_CNT;

  // a range must start and end on pair boundaries inside the pair area
  wire pair_split = !is_bool &&
                    ((({1'b0, start_ff} >= PAIR_BASE[16:0]) && start_ff[0]) ||
                     ((end_c > PAIR_BASE[16:0]) && end_c[0]));

  // checks run in fixed order; the first failing one names the error
  reg [7:0] err_c;
  always @* begin
    if (!func_ok)
      err_c = `ERR_FUNC;
    else if (count_ff == 16'h0000 || cnt17 > maxq_c)
      err_c = `ERR_VALUE;
    else if (end_c > limit_c || pair_split)
      err_c = `ERR_ADDR;
    // fault is looked at in this cycle only; a later fault goes unreported
    else if (io_fault)
      err_c = `ERR_FAIL;
    else
      err_c = `ERR_NONE;
  end

  // payload size is fixed by the code and count alone, so a refused write is still
  // drained fully and the next request starts in step
  wire [16:0] plen_c = is_wr_bool ? bytes_c :
                       (is_wr_word ? {count_ff, 1'b0} : 17'h00000);

  wire [7:0] len_c = is_rd_bool ? bytes_c[7:0] :
                     ((is_rd_word | is_rd_ro) ? {count_ff[6:0], 1'b0} : 8'h00);

  // ----------------------------------------------------------------
  // response data selection
  // ----------------------------------------------------------------
  reg  [15:0] word_c;
  reg  [7:0]  pack_c;
  always @* begin
    word_c = ram_rdata;
    if (is_rd_ro && idx_ff < NRO[16:0])
      word_c = ro_regs[idx_ff[WAW-1:0]*16 +: 16];
    // bits past the count read as zero
    pack_c = 8'h00;
    for (j = 0; j < 8; j = j + 1) begin
      if (j < rem_ff && idx_ff + j < NBOOL)
        pack_c[j] = bool_ff[idx_ff + j];
    end
  end

  // ----------------------------------------------------------------
  // response byte order
  // ----------------------------------------------------------------
  always @* begin
    fifo_in_valid = 1'b0;
    fifo_in_data  = 8'h00;
    case (state_ff)
      S_CODE: begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = (err_ff != `ERR_NONE) ? (func_ff | `FN_ERR_FLAG) : func_ff;
      end
      S_LEN: begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = (err_ff != `ERR_NONE) ? err_ff : len_ff;
      end
      S_WORD: begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = phase_ff ? word_c[7:0] : word_c[15:8];
      end
      S_BOOL: begin
        fifo_in_valid = 1'b1;
        fifo_in_data  = pack_c;
      end
      default: begin
        fifo_in_valid = 1'b0;
        fifo_in_data  = 8'h00;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_HDR:
        if (take && hdr_cnt_ff == `HDR_LAST)
          nxt_state = S_CHK;
      S_CHK:
        nxt_state = (plen_c != 17'h00000) ? S_PAY : S_CODE;
      S_PAY:
        if (take && pay_ff == 17'h00001)
          nxt_state = S_CODE;
      S_CODE:
        if (push)
          nxt_state = S_LEN;
      S_LEN:
        if (push) begin
          if (err_ff != `ERR_NONE || is_write || len_ff == 8'h00)
            nxt_state = S_HDR;
          else if (is_rd_bool)
            nxt_state = S_BOOL;
          else
            nxt_state = S_FETCH;
        end
      // one idle cycle lets the registered store present the word
      S_FETCH:
        nxt_state = S_WORD;
      S_WORD:
        if (push && phase_ff)
          nxt_state = (rem_ff == 17'h00001) ? S_HDR : S_FETCH;
      S_BOOL:
        if (push && rem_ff <= `BOOLS_PER_BYTE)
          nxt_state = S_HDR;
      default:
        nxt_state = S_HDR;
    endcase
  end

  // ----------------------------------------------------------------
  // request capture and counters
  // ----------------------------------------------------------------
  wire wr_word_now = (state_ff == S_PAY) && take && is_wr_word &&
                     phase_ff && (err_ff == `ERR_NONE);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= S_HDR;
      hdr_cnt_ff <= 3'h0;
      func_ff    <= 8'h00;
      start_ff   <= 16'h0000;
      count_ff   <= 16'h0000;
      err_ff     <= `ERR_NONE;
      len_ff     <= 8'h00;
      pay_ff     <= 17'h00000;
      idx_ff     <= 17'h00000;
      rem_ff     <= 17'h00000;
      phase_ff   <= 1'b0;
      hi_ff      <= 8'h00;
      bool_ff    <= {NBOOL{1'b0}};
    end else begin
      state_ff <= nxt_state;
      case (state_ff)
        S_HDR:
          if (take) begin
            hdr_cnt_ff <= (hdr_cnt_ff == `HDR_LAST) ? 3'h0 : hdr_cnt_ff + 3'h1;
            case (hdr_cnt_ff)
              `HDR_FUNC:     func_ff         <= rx_data;
              `HDR_START_HI: start_ff[15:8]  <= rx_data;
              `HDR_START_LO: start_ff[7:0]   <= rx_data;
              `HDR_CNT_HI:   count_ff[15:8]  <= rx_data;
              default:       count_ff[7:0]   <= rx_data;
            endcase
          end
        S_CHK: begin
          err_ff   <= err_c;
          len_ff   <= len_c;
          pay_ff   <= plen_c;
          idx_ff   <= {1'b0, start_ff};
          rem_ff   <= cnt17;
          phase_ff <= 1'b0;
        end
        S_PAY:
          if (take) begin
            pay_ff <= pay_ff - 17'h00001;
            if (is_wr_word) begin
              phase_ff <= ~phase_ff;
              if (!phase_ff)
                hi_ff <= rx_data;
              else
                idx_ff <= idx_ff + 17'h00001;
            end else begin
              if (err_ff == `ERR_NONE) begin
                // bits past the count are ignored, so a short last byte is harmless
                for (k = 0; k < NBOOL; k = k + 1) begin
                  if (k >= idx_ff && k - idx_ff < 8 && k - idx_ff < rem_ff)
                    bool_ff[k] <= rx_data[k - idx_ff];
                end
              end
              idx_ff <= idx_ff + `BOOLS_PER_BYTE;
              rem_ff <= (rem_ff > `BOOLS_PER_BYTE) ? rem_ff - `BOOLS_PER_BYTE : 17'h00000;
            end
          end
        S_CODE: begin
          idx_ff   <= {1'b0, start_ff};
          rem_ff   <= cnt17;
          phase_ff <= 1'b0;
        end
        S_WORD:
          if (push) begin
            phase_ff <= ~phase_ff;
            if (phase_ff) begin
              idx_ff <= idx_ff + 17'h00001;
              rem_ff <= rem_ff - 17'h00001;
            end
          end
        S_BOOL:
          if (push) begin
            idx_ff <= idx_ff + `BOOLS_PER_BYTE;
            rem_ff <= (rem_ff > `BOOLS_PER_BYTE) ? rem_ff - `BOOLS_PER_BYTE : 17'h00000;
          end
        default: begin
          hdr_cnt_ff <= hdr_cnt_ff;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // word store and response queue
  // ----------------------------------------------------------------
  // a word is committed only once its low byte arrives, so a pair never
  // shows a half-written value to a read
  io_word_ram #(
    .DW    (16),
    .DEPTH (NWORD)
  ) u_ram (
    .clk_sys    (clk_sys),
    .wr_en      (wr_word_now),
    .wr_addr    (idx_ff[WAW-1:0]),
    .wr_data    ({hi_ff, rx_data}),
    .rd_addr    (idx_ff[WAW-1:0]),
    .rd_data_ff (ram_rdata)
  );

  // the sequencer stalls on a full queue, so a slow reader throttles reads
  io_byte_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );
endmodule

`default_nettype wire

/* test/io_api_checker.sv */
`include "io_api_map.vh"
`default_nettype none

// ------------------------------
// stream protocol checks
// ------------------------------
module io_api_checker #(
  parameter NBOOL = 16,
  parameter NRO   = 16
) (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst_n,
  // request stream
  input wire logic              rx_valid,
  input wire logic [7:0]        rx_data,
  input wire logic              rx_ready,
  // response stream
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic [7:0]        tx_data,
  // register space
  input wire logic [NBOOL-1:0]  bool_out,
  input wire logic [NRO*16-1:0] ro_regs,
  input wire logic              io_fault
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0]  taken_ff;
  logic [7:0]  code_ff;
  logic [10:0] wait_ff;
  logic [7:0]  cnt_hi_ff;
  logic [16:0] pay_ff;
  logic [16:0] cnt_c;
  logic [16:0] pay_c;

  // payload length expected from the header, worked out from the rules
  assign cnt_c = {1'b0, cnt_hi_ff, rx_data};
  assign pay_c = (code_ff == `FN_WR_BOOL) ? (cnt_c + 17'h00007) >> 3 :
                 (code_ff == `FN_WR_WORD) ? {cnt_c[15:0], 1'b0} : 17'h00000;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // header bytes are counted only while no payload is due
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      taken_ff  <= 3'h0;
      code_ff   <= 8'h00;
      wait_ff   <= 11'h000;
      cnt_hi_ff <= 8'h00;
      pay_ff    <= 17'h00000;
    end else begin
      if (rx_valid && rx_ready) begin
        if (pay_ff != 17'h00000) begin
          pay_ff <= pay_ff - 17'h00001;
        end else begin
          taken_ff <= (taken_ff == 3'h4) ? 3'h0 : taken_ff + 3'h1;
          if (taken_ff == 3'h0)
            code_ff <= rx_data;
          if (taken_ff == 3'h3)
            cnt_hi_ff <= rx_data;
          if (taken_ff == 3'h4)
            pay_ff <= pay_c;
        end
      end
      wait_ff <= (!rx_ready && tx_ready) ? wait_ff + 11'h001 : 11'h000;
    end
  end

  a_valid_hold: assert property (tx_valid && !tx_ready |=> tx_valid)
    else $error("response byte withdrawn");
  a_data_hold: assert property (tx_valid && !tx_ready |=> $stable(tx_data))
    else $error("response byte changed while stalled");
  a_resp_prompt: assert property ($fell(rx_ready) && !tx_valid |-> (##1 rx_ready) or (##[1:4] tx_valid))
    else $error("no response after request");
  a_push_busy: assert property ($rose(tx_valid) |-> !$past(rx_ready))
    else $error("response pushed while idle");
  a_hdr_open: assert property (rx_valid && rx_ready && pay_ff == 17'h00000 && taken_ff < 3'h4 |=> rx_ready)
    else $error("header cut short");
  a_hdr_close: assert property (rx_valid && rx_ready && pay_ff == 17'h00000 && taken_ff == 3'h4
    && pay_c == 17'h00000 |=> !rx_ready ##1 !rx_ready)
    else $error("read request not closed after header");
  a_pay_open: assert property (rx_valid && rx_ready && pay_ff == 17'h00000 && taken_ff == 3'h4
    && pay_c != 17'h00000 |=> !rx_ready ##1 rx_ready)
    else $error("write payload not opened after header");
  a_pay_close: assert property (rx_valid && rx_ready && pay_ff == 17'h00001 |=> !rx_ready)
    else $error("request not closed after payload");
  a_bool_quiet: assert property (!$stable(bool_out) |-> code_ff == `FN_WR_BOOL)
    else $error("boolean registers changed outside a write");
  a_ready_return: assert property (wait_ff < 11'h3E8)
    else $error("engine busy too long");

  cover property (code_ff == `FN_WR_BOOL && $fell(rx_ready));
  cover property (tx_valid && !tx_ready ##1 tx_valid && !tx_ready);
  cover property (tx_valid && tx_ready && tx_data == 8'h84);
  cover property (io_fault && $fell(rx_ready));
endmodule

bind io_api_engine io_api_checker #(.NBOOL(NBOOL), .NRO(NRO)) u_io_api_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .bool_out(bool_out),
  .ro_regs(ro_regs), .io_fault(io_fault));

`default_nettype wire

/* test/io_host_model.sv */
`default_nettype none

// ------------------------------
// host writing requests, reading answers
// ------------------------------
module io_host_model (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // request stream
  output var logic        rx_valid,
  output var logic [7:0]  rx_data,
  input wire logic        rx_ready,
  // response stream
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  output var logic        tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] rsp[$];
  logic [1:0] ph;
  bit         slow;
  bit         hung;

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end

  // slow mode takes one byte in four so the engine's queue backs up
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph       <= 2'h0;
      tx_ready <= 1'b1;
    end else begin
      ph       <= ph + 2'h1;
      tx_ready <= !slow || ph == 2'h3;
      if (tx_valid && tx_ready)
        rsp.push_back(tx_data);
    end
  end

  task send(input logic [7:0] q[$]);
    int n;
    @(posedge clk_sys);
    foreach (q[i]) begin
      rx_valid <= 1'b1;
      rx_data  <= q[i];
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (rx_ready !== 1'b1 && n < 2000);
      if (n == 2000)
        hung = 1'b1;
    end
    rx_valid <= 1'b0;
    // released line shows the inverse so a stale byte cannot pass
    rx_data <= ~q[q.size()-1];
  endtask
endmodule

`default_nettype wire

/* test/io_api_engine_tb.sv */
`default_nettype none

module io_api_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef logic [7:0] bq_t[$];

  logic         clk_sys;
  logic         rst_n;
  logic         rx_valid;
  logic [7:0]   rx_data;
  logic         rx_ready;
  logic         tx_valid;
  logic         tx_ready;
  logic [7:0]   tx_data;
  logic [15:0]  bool_out;
  logic [255:0] ro_regs;
  logic         io_fault;
  int           n_fail;
  int           checks;

  always #10 clk_sys = ~clk_sys;

  io_api_engine u_io_api_engine (
    .clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .bool_out(bool_out),
    .ro_regs(ro_regs), .io_fault(io_fault));

  io_host_model u_io_host_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  // ------------------------------
  // helpers
  // ------------------------------
  task print_verdict;
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // splits a literal into n bytes, most significant first
  function automatic bq_t b(input logic [127:0] v, input int n);
    bq_t q;
    for (int i = n - 1; i >= 0; i--)
      q.push_back(v[8*i+:8]);
    return q;
  endfunction

  // trailing quiet cycles catch any byte sent beyond the expected answer
  task run(input bq_t req, input bq_t exp);
    int n;
    u_io_host_model.rsp.delete();
    u_io_host_model.send(req);
    n = 0;
    while (u_io_host_model.rsp.size() < exp.size() && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 3000 || u_io_host_model.hung) begin
      n_fail++;
      print_verdict();
    end else begin
      repeat (20) @(posedge clk_sys);
      chk(u_io_host_model.rsp.size(), exp.size());
      foreach (exp[i])
        chk(u_io_host_model.rsp[i], exp[i]);
    end
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  task t_word;
    run(b(72'h1000020002A55A1234, 9), b(16'h1000, 2));
    run(b(40'h0300020002, 5), b(48'h0304A55A1234, 6));
    run(b(72'h100010000201020304, 9), b(16'h1000, 2));
    run(b(40'h0300100002, 5), b(48'h030401020304, 6));
  endtask

  task t_bool;
    run(b(56'h0F0003000A35FE, 7), b(16'h0F00, 2));
    chk(bool_out, 32'h000011A8);
    run(b(40'h010003000A, 5), b(32'h01023502, 4));
  endtask

  task t_ro;
    bq_t e;
    e = {8'h04, 8'h10};
    for (int k = 0; k < 8; k++) begin
      e.push_back({4'hC, k[3:0]});
      e.push_back({4'h3, ~k[3:0]});
    end
    u_io_host_model.slow = 1'b1;
    run(b(40'h0400000008, 5), e);
    u_io_host_model.slow = 1'b0;
    chk(tx_valid, 32'h0);
  endtask

  task t_err;
    run(b(40'h0200000001, 5), b(16'h8201, 2));
    run(b(40'h0300000000, 5), b(16'h8303, 2));
    run(b(40'h01000007D1, 5), b(16'h8103, 2));
    run(b(40'h03001F0002, 5), b(16'h8302, 2));
    run(b(40'h0300110002, 5), b(16'h8302, 2));
    run(b(48'h0F000F000203, 6), b(16'h8F02, 2));
    chk(bool_out, 32'h000011A8);
    run(b(104'h10001E00041111222233334444, 13), b(16'h9002, 2));
    run(b(40'h0300020001, 5), b(32'h0302A55A, 4));
    @(posedge clk_sys);
    io_fault <= 1'b1;
    run(b(40'h0400000001, 5), b(16'h8404, 2));
    io_fault <= 1'b0;
  endtask

  initial begin
    clk_sys  = 1'b0;
    rst_n    = 1'b0;
    io_fault = 1'b0;
    for (int k = 0; k < 16; k++)
      ro_regs[16*k+:16] = {4'hC, k[3:0], 4'h3, ~k[3:0]};
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_word();
    t_bool();
    t_ro();
    t_err();
    print_verdict();
  end
endmodule

`default_nettype wire
